// file: bench/fsr_array_model.sv
// array engine model facing the status bank: times program, erase and
// status writes, and pauses them when the bench asks for a suspend
// assumes op_start is a combinational pulse in the accept cycle
`timescale 1ns/1ns
`default_nettype none
module fsr_array_model (
  input wire logic core_clk, // bank clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic op_start, // start pulse from the bank
  input wire logic slow, // long operation when high
  input wire logic sus_cmd, // bench asks for a suspend
  input wire logic res_cmd, // bench asks for a resume
  output logic op_done, // completion pulse
  output logic op_suspended, // paused pulse
  output logic op_resumed // resumed pulse
);
  logic start_q;
  logic running;
  logic paused;
  int cnt;
  // ********************************************************************
  // engine timing
  // ********************************************************************
  // op_start is combinational, so it is caught on the taking edge
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= op_start;
    end
  end
  // answers move on the falling edge, well clear of the sampling edge
  always @(negedge core_clk or posedge rst) begin
    if (rst) begin
      {op_done, op_suspended, op_resumed, running, paused} <= 5'h00;
      cnt <= 0;
    end else begin
      {op_done, op_suspended, op_resumed} <= 3'h0;
      if (start_q && !running) begin
        running <= 1'b1;
        cnt <= slow ? 20 : 3;
      end else if (running && !paused && sus_cmd) begin
        paused <= 1'b1;
        op_suspended <= 1'b1;
      end else if (paused && res_cmd) begin
        paused <= 1'b0;
        op_resumed <= 1'b1;
      end else if (running && !paused) begin
        if (cnt == 0) begin
          op_done <= 1'b1;
          running <= 1'b0;
        end else begin
          cnt <= cnt - 1;
        end
      end
    end
  end
endmodule : fsr_array_model
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the flash status register bank
// assumes fsr_array_model as the array engine behind the bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  import fsr_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  fsr_cmd_s cmd = '0;
  logic write_protect_n = 1'b1;
  logic slow = 1'b0;
  logic sus_cmd = 1'b0;
  logic res_cmd = 1'b0;
  logic op_done, op_suspended, op_resumed, op_start, rd_valid, last_start, last_rv, q;
  logic [7:0] rd_data, last_rd, d;
  logic [31:0] seed = 32'h0D965BCC;
  fsr_status_s status;
  fsr_cfg_s cfg;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  // ********************************************************************
  // clock, instances, helpers
  // ********************************************************************
  always #4 core_clk = ~core_clk;
  fsr_status_bank fsr_status_bank_i (.core_clk(core_clk), .rst(rst), .cmd(cmd),
    .op_done(op_done), .op_suspended(op_suspended), .op_resumed(op_resumed),
    .write_protect_n(write_protect_n), .op_start(op_start), .rd_valid(rd_valid),
    .rd_data(rd_data), .status(status), .cfg(cfg));
  fsr_array_model fsr_array_model_i (.core_clk(core_clk), .rst(rst), .op_start(op_start),
    .slow(slow), .sus_cmd(sus_cmd), .res_cmd(res_cmd), .op_done(op_done),
    .op_suspended(op_suspended), .op_resumed(op_resumed));
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // one command pulse; op_start is looked at inside its accept cycle
  task automatic issue(input logic [7:0] op, input logic [7:0] data);
    @(negedge core_clk);
    cmd <= '{1'b1, op, data};
    #2 last_start = op_start;
    @(negedge core_clk);
    last_rv = rd_valid;
    last_rd = rd_data;
    cmd <= '0;
  endtask : issue
  // one step of the bench's shift-register source of random bytes
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr_next
  task automatic rnd;
    seed = lfsr_next(seed);
    d = seed[7:0];
  endtask : rnd
  // second register after a volatile write: no suspend, locks clear, lock zero set
  function automatic logic [7:0] exp_second(input logic [7:0] w);
    exp_second = {1'b0, w[6], 3'b000, 1'b1, w[1], w[0]};
  endfunction : exp_second
  task automatic wait_idle;
    for (int i = 0; i < 60 && status.first_status_register[0] !== 1'b0; i++)
      @(negedge core_clk);
  endtask : wait_idle
  // a hang is cut short here and still reaches the verdict
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end
  // ********************************************************************
  // scenarios
  // ********************************************************************
  initial begin
    repeat (2) @(negedge core_clk);
    rst <= 1'b0;
    check(status, {8'h00, 8'h04, 8'h40});
    check(cfg.security_lock, 4'h1);
    issue(OP_READ_FIRST, 8'h00);
    check({last_rv, last_rd}, 9'h100);
    // random volatile writes, read-only bits offered as random values
    for (int n = 0; n < 6; n++) begin
      rnd();
      issue(OP_VOLATILE_ENABLE, 8'h00);
      issue(OP_WRITE_FIRST, d);
      check({last_start, status.first_status_register}, {1'b0, d[7:2], 2'b00});
      rnd();
      q = d[1];
      issue(OP_VOLATILE_ENABLE, 8'h00);
      issue(OP_WRITE_SECOND, {d[7:1], 1'b0});
      check(status.second_status_register, exp_second({d[7:1], 1'b0}));
      rnd();
      issue(OP_VOLATILE_ENABLE, 8'h00);
      issue(OP_WRITE_THIRD, d);
      check(status.third_status_register, d);
      check(cfg.variable_latency_en, d[3:0] != 4'h0);
      check({cfg.wp_fn_en, cfg.hold_fn_en, cfg.reset_fn_en}, {~q, ~q & ~d[7], ~q & d[7]});
    end
    // pin protection and quad override
    issue(OP_VOLATILE_ENABLE, 8'h00);
    issue(OP_WRITE_SECOND, 8'h00);
    issue(OP_VOLATILE_ENABLE, 8'h00);
    issue(OP_WRITE_FIRST, 8'h80);
    write_protect_n <= 1'b0;
    issue(OP_VOLATILE_ENABLE, 8'h00);
    issue(OP_WRITE_FIRST, 8'h1C);
    check(status.first_status_register, 8'h80);
    write_protect_n <= 1'b1;
    issue(OP_VOLATILE_ENABLE, 8'h00);
    issue(OP_WRITE_SECOND, 8'h02);
    write_protect_n <= 1'b0;
    issue(OP_VOLATILE_ENABLE, 8'h00);
    issue(OP_WRITE_FIRST, 8'h1C);
    check(status.first_status_register, 8'h1C);
    write_protect_n <= 1'b1;
    issue(OP_WRITE_FIRST, 8'hE0);
    check(status.first_status_register, 8'h1C);
    // latency restored when leaving the four-wire command mode
    issue(OP_VOLATILE_ENABLE, 8'h00);
    issue(OP_WRITE_THIRD, 8'h4F);
    issue(OP_QPI_ENTER, 8'h00);
    check(cfg.qpi_mode, 1'b1);
    issue(OP_QPI_EXIT, 8'h00);
    check({cfg.qpi_mode, status.third_status_register}, 9'h040);
    // non-volatile write refused until a software reset
    issue(OP_WRITE_ENABLE, 8'h00);
    check(status.first_status_register[1], 1'b1);
    issue(OP_WRITE_FIRST, 8'h24);
    check({last_start, status.first_status_register[7:2]}, 7'h07);
    issue(OP_RESET_ARM, 8'h00);
    issue(OP_RESET_GO, 8'h00);
    check(status, {8'h00, 8'h04, 8'h40});
    // slow non-volatile write, polled while busy
    slow <= 1'b1;
    rnd();
    issue(OP_WRITE_ENABLE, 8'h00);
    issue(OP_WRITE_FIRST, {1'b0, d[6:0]});
    check({last_start, status.first_status_register}, 9'h103);
    issue(OP_VOLATILE_ENABLE, 8'h00);
    issue(OP_READ_FIRST, 8'h00);
    check({last_rv, last_rd}, 9'h103);
    wait_idle();
    check(status.first_status_register, {1'b0, d[6:2], 2'b00});
    // non-volatile second register write sets one-time locks
    issue(OP_WRITE_ENABLE, 8'h00);
    issue(OP_WRITE_SECOND, 8'h3C);
    wait_idle();
    check({cfg.security_lock, status.second_status_register}, 12'hF3C);
    check(cfg.prot, {1'b0, d[6:2], 3'b000});
    // write disable drops the latch, program needs the latch, then suspend and resume it
    issue(OP_WRITE_ENABLE, 8'h00);
    issue(OP_WRITE_DISABLE, 8'h00);
    check(status.first_status_register[1], 1'b0);
    issue(OP_PAGE_PROGRAM, 8'h00);
    check(last_start, 1'b0);
    issue(OP_WRITE_ENABLE, 8'h00);
    issue(OP_PAGE_PROGRAM, 8'h00);
    sus_cmd <= 1'b1;
    repeat (3) @(negedge core_clk);
    sus_cmd <= 1'b0;
    check({status.second_status_register[7], status.first_status_register[0]}, 2'h2);
    res_cmd <= 1'b1;
    repeat (3) @(negedge core_clk);
    res_cmd <= 1'b0;
    check({status.second_status_register[7], status.first_status_register[0]}, 2'h1);
    wait_idle();
    check(status.first_status_register[1:0], 2'h0);
    // short sector erase with the latch set
    slow <= 1'b0;
    issue(OP_WRITE_ENABLE, 8'h00);
    issue(OP_SECTOR_ERASE, 8'h00);
    check({last_start, status.first_status_register[1:0]}, 3'h7);
    wait_idle();
    check(status.first_status_register[1:0], 2'h0);
    summarize();
  end
endmodule : tb
`default_nettype wire

// file: design/fsr_pkg.sv
// constants, command codes and carriers for the flash status register bank
// assumes a command sequencer that delivers whole decoded opcodes and data bytes
`default_nettype none
package fsr_pkg;

  // ********************************************************************
  // command opcodes as delivered by the serial front end
  // ********************************************************************
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_VOLATILE_ENABLE = 8'h50;
  localparam logic [7:0] OP_WRITE_FIRST = 8'h01;
  localparam logic [7:0] OP_WRITE_SECOND = 8'h31;
  localparam logic [7:0] OP_WRITE_THIRD = 8'h11;
  localparam logic [7:0] OP_READ_FIRST = 8'h05;
  localparam logic [7:0] OP_READ_SECOND = 8'h35;
  localparam logic [7:0] OP_READ_THIRD = 8'h15;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_GO = 8'h99;
  localparam logic [7:0] OP_QPI_ENTER = 8'h38;
  localparam logic [7:0] OP_QPI_EXIT = 8'hFF;

  // ********************************************************************
  // field positions within the written data byte
  // ********************************************************************
  localparam int B_SEL_ZERO = 7;
  localparam int B_GRAN = 6;
  localparam int B_DIR = 5;
  localparam int B_RANGE_MSB = 4;
  localparam int B_RANGE_LSB = 2;
  localparam int B_CMP = 6;
  localparam int B_LOCK_MSB = 5;
  localparam int B_LOCK_LSB = 2;
  localparam int B_QUAD = 1;
  localparam int B_SEL_ONE = 0;

  // ********************************************************************
  // carriers
  // ********************************************************************
  typedef struct packed {
    logic protect_selector_zero;
    logic protect_granularity;
    logic protect_direction;
    logic [2:0] protect_range;
    logic complement_protection;
    logic quad_enable;
    logic protect_selector_one;
  } fsr_prot_s;

  typedef struct packed {
    logic shared_pin_function_select;
    logic drive_strength_high;
    logic drive_strength_low;
    logic high_frequency_enable;
    logic [3:0] read_latency_field;
  } fsr_third_s;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] data;
  } fsr_cmd_s;

  typedef struct packed {
    logic [7:0] first_status_register;
    logic [7:0] second_status_register;
    logic [7:0] third_status_register;
  } fsr_status_s;

  typedef struct packed {
    fsr_prot_s prot;
    logic [3:0] security_lock;
    logic wp_fn_en;
    logic hold_fn_en;
    logic reset_fn_en;
    logic qpi_mode;
    logic variable_latency_en;
  } fsr_cfg_s;

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam fsr_prot_s PROT_RESET = '0;
  localparam logic [3:0] LOCK_RESET = 4'h0;
  localparam logic [3:0] LC_RESET = 4'h0;
  localparam logic [3:0] LC_FIXED = 4'h0;
  localparam fsr_third_s THIRD_RESET = '{1'h0, 1'h1, 1'h0, 1'h0, LC_RESET};
  localparam logic LOCK_ZERO_FIXED = 1'h1;

endpackage : fsr_pkg
`default_nettype wire

// file: design/fsr_status_bank.sv
// flash status register bank: three status registers, volatile and
// non-volatile copies of the first two, write-enable, busy and suspend state
// assumes a sequencer that hands over decoded commands one per cycle and an
// array engine that reports completion, suspend and resume as one-cycle pulses
//
// Overview of operation
// - first register bit 7: protect selector zero
// - first register bit 6: 64 kB or 4 kB granularity
// - first register bit 5: range from top or bottom
// - first register bit 1: read-only write-enable latch
// - first register bit 0: read-only busy flag
// - while busy only status reads are accepted
// - busy clears when the operation finishes
// - second register bit 7: read-only suspend flag
// - second register bit 6: complement protection map
// - second register bits 5..2: one-time security locks
// - security register zero always reads locked
// - second register bit 1: quad enable, pins become data
// - second register bit 0: protect selector one
// - protection bits kept in volatile and non-volatile copies
// - non-volatile write refused after volatile write
// - third register bit 7: hold or reset pin
// - pin function only active while quad disabled
// - third register bits 6..5: drive strength, reset 10
// - third register bit 4: high-frequency enable
// - third register bits 3..0: read latency cycles
// - latency zero selects fixed per-command latency
// - leaving quad-peripheral mode restores latency default
// - write enable picks non-volatile, volatile enable volatile
// - latch set by write enable, cleared at completion
`timescale 1ns/1ns
`default_nettype none
module fsr_status_bank (
  input wire logic core_clk,                   // system clock, 125 MHz
  input wire logic rst,                        // asynchronous reset, active high
  input wire fsr_pkg::fsr_cmd_s cmd,           // decoded command from sequencer
  input wire logic op_done,                    // array or non-volatile write finished
  input wire logic op_suspended,               // array engine paused the operation
  input wire logic op_resumed,                 // array engine resumed the operation
  input wire logic write_protect_n,            // write-protect pin, low protects
  output logic op_start,                       // start pulse to the array engine
  output logic rd_valid,                       // read data valid pulse
  output logic [7:0] rd_data,                  // status byte for a read command
  output fsr_pkg::fsr_status_s status,         // live view of all three registers
  output fsr_pkg::fsr_cfg_s cfg                // effective configuration
);
  import fsr_pkg::*;

  // ********************************************************************
  // helper functions
  // ********************************************************************
  // status reads are the only commands that pass while busy
  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == OP_READ_FIRST) || (op == OP_READ_SECOND) || (op == OP_READ_THIRD);
  endfunction : is_read

  // protection check from the selector bits and the write-protect pin
  function automatic logic wr_allowed(input fsr_prot_s p, input logic wp_n);
    if (p.protect_selector_one) begin
      wr_allowed = 1'h0;                        // lock-down or one-time lock
    end else if (p.protect_selector_zero) begin
      wr_allowed = p.quad_enable | wp_n;        // pin ignored once it is a data line
    end else begin
      wr_allowed = 1'h1;
    end
  endfunction : wr_allowed

  // merges a written byte into a protection copy
  function automatic fsr_prot_s merge_prot(input fsr_prot_s base, input logic [7:0] op,
                                           input logic [7:0] d);
    merge_prot = base;
    if (op == OP_WRITE_FIRST) begin
      merge_prot.protect_selector_zero = d[B_SEL_ZERO];
      merge_prot.protect_granularity = d[B_GRAN];
      merge_prot.protect_direction = d[B_DIR];
      merge_prot.protect_range = d[B_RANGE_MSB:B_RANGE_LSB];
    end else begin
      merge_prot.complement_protection = d[B_CMP];
      merge_prot.quad_enable = d[B_QUAD];
      merge_prot.protect_selector_one = d[B_SEL_ONE];
    end
  endfunction : merge_prot

  // ********************************************************************
  // state
  // ********************************************************************
  fsr_prot_s nv_q, nv_d, vol_q, vol_d, pend_q, pend_d;
  fsr_third_s third_q, third_d;
  logic [3:0] lock_q, lock_d, pend_lock_q, pend_lock_d;
  logic wel_q, wel_d, busy_q, busy_d, sus_q, sus_d;
  logic vwe_q, vwe_d, volw_q, volw_d, pend_nv_q, pend_nv_d;
  logic arm_q, arm_d, qpi_q, qpi_d, rd_valid_q, rd_valid_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic accept;
  logic [7:0] first_view, second_view;
  fsr_prot_s wr_vol, wr_nv;

  // register images; latch, busy and suspend come from live flags only
  assign first_view = {vol_q.protect_selector_zero,
                       vol_q.protect_granularity,
                       vol_q.protect_direction,
                       vol_q.protect_range,
                       wel_q,
                       busy_q};
  assign second_view = {sus_q,
                        vol_q.complement_protection,
                        lock_q[3:1],
                        LOCK_ZERO_FIXED,
                        vol_q.quad_enable,
                        vol_q.protect_selector_one};
  assign status = '{first_view, second_view, third_q};

  // effective configuration; the volatile copy governs behaviour
  assign cfg.prot = vol_q;
  assign cfg.security_lock = {lock_q[3:1], LOCK_ZERO_FIXED};
  assign cfg.wp_fn_en = ~vol_q.quad_enable;
  assign cfg.hold_fn_en = ~vol_q.quad_enable & ~third_q.shared_pin_function_select;
  assign cfg.reset_fn_en = ~vol_q.quad_enable & third_q.shared_pin_function_select;
  assign cfg.qpi_mode = qpi_q;
  assign cfg.variable_latency_en = (third_q.read_latency_field != LC_FIXED);
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  // candidate images for a status write
  assign wr_vol = merge_prot(vol_q, cmd.opcode, cmd.data);
  assign wr_nv = merge_prot(nv_q, cmd.opcode, cmd.data);
  // only reads get through while an operation runs
  assign accept = cmd.valid & (~busy_q | is_read(cmd.opcode));

  // ********************************************************************
  // next-state logic
  // ********************************************************************
  // completion is applied first; while busy no write can collide with it
  always_comb begin
    nv_d = nv_q;
    vol_d = vol_q;
    pend_d = pend_q;
    pend_lock_d = pend_lock_q;
    pend_nv_d = pend_nv_q;
    third_d = third_q;
    lock_d = lock_q;
    wel_d = wel_q;
    busy_d = busy_q;
    sus_d = sus_q;
    vwe_d = vwe_q;
    volw_d = volw_q;
    arm_d = arm_q;
    qpi_d = qpi_q;
    rd_valid_d = 1'h0;
    rd_data_d = rd_data_q;
    op_start = 1'h0;
    if (busy_q && op_done) begin
      busy_d = 1'h0;
      wel_d = 1'h0;
      if (pend_nv_q) begin
        nv_d = pend_q;
        vol_d = pend_q;
        lock_d = lock_q | pend_lock_q;                 // one-time bits only ever set
        pend_nv_d = 1'h0;
      end
    end
    // a suspended operation frees the command path until resumed
    if (busy_q && op_suspended) begin
      sus_d = 1'h1;
      busy_d = 1'h0;
    end else if (sus_q && op_resumed) begin
      sus_d = 1'h0;
      busy_d = 1'h1;
    end
    if (accept) begin
      arm_d = (cmd.opcode == OP_RESET_ARM);
      unique case (cmd.opcode)
        OP_WRITE_ENABLE: begin
          wel_d = 1'h1;
          vwe_d = 1'h0;
        end
        OP_WRITE_DISABLE: begin
          wel_d = 1'h0;
          vwe_d = 1'h0;
        end
        OP_VOLATILE_ENABLE: vwe_d = 1'h1;
        OP_WRITE_THIRD: begin
          // the third register is volatile and not guarded by the selectors
          if (vwe_q) begin
            third_d = cmd.data;
          end
          vwe_d = 1'h0;
        end
        OP_WRITE_FIRST, OP_WRITE_SECOND: begin
          // only protection fields are taken; read-only flags stay put
          if (vwe_q && wr_allowed(vol_q, write_protect_n)) begin
            vol_d = wr_vol;
            volw_d = 1'h1;
          end else if (wel_q && !vwe_q && !volw_q && wr_allowed(vol_q, write_protect_n)) begin
            pend_d = wr_nv;
            pend_lock_d = LOCK_RESET;
            if (cmd.opcode == OP_WRITE_SECOND) begin
              pend_lock_d = {cmd.data[B_LOCK_MSB:B_LOCK_LSB + 1], 1'h0};
            end
            pend_nv_d = 1'h1;
            busy_d = 1'h1;
            op_start = 1'h1;
          end
          vwe_d = 1'h0;
        end
        OP_PAGE_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE: begin
          if (wel_q) begin
            busy_d = 1'h1;
            op_start = 1'h1;
          end
          vwe_d = 1'h0;
        end
        OP_READ_FIRST: begin
          rd_valid_d = 1'h1;
          rd_data_d = first_view;
        end
        OP_READ_SECOND: begin
          rd_valid_d = 1'h1;
          rd_data_d = second_view;
        end
        OP_READ_THIRD: begin
          rd_valid_d = 1'h1;
          rd_data_d = third_q;
        end
        OP_RESET_GO: begin
          // software reset reloads volatile copies and releases supply lock-down
          if (arm_q) begin
            vol_d = nv_q;
            if (nv_q.protect_selector_one && !nv_q.protect_selector_zero) begin
              vol_d.protect_selector_one = 1'h0;
            end
            third_d = THIRD_RESET;
            wel_d = 1'h0;
            vwe_d = 1'h0;
            volw_d = 1'h0;
            sus_d = 1'h0;
            qpi_d = 1'h0;
          end
        end
        OP_QPI_ENTER: qpi_d = qpi_q | vol_q.quad_enable;
        OP_QPI_EXIT: begin
          if (qpi_q) begin
            qpi_d = 1'h0;
            third_d.read_latency_field = LC_RESET;
          end
        end
        default: ;
      endcase
    end
  end

  // ********************************************************************
  // registers
  // ********************************************************************
  // hardware reset stands for a power cycle: both copies fall to factory values
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_q <= PROT_RESET;
      vol_q <= PROT_RESET;
      pend_q <= PROT_RESET;
      pend_lock_q <= LOCK_RESET;
      pend_nv_q <= 1'h0;
      third_q <= THIRD_RESET;
      lock_q <= LOCK_RESET;
      wel_q <= 1'h0;
      busy_q <= 1'h0;
      sus_q <= 1'h0;
      vwe_q <= 1'h0;
      volw_q <= 1'h0;
      arm_q <= 1'h0;
      qpi_q <= 1'h0;
      rd_valid_q <= 1'h0;
      rd_data_q <= 8'h00;
    end else begin
      nv_q <= nv_d;
      vol_q <= vol_d;
      pend_q <= pend_d;
      pend_lock_q <= pend_lock_d;
      pend_nv_q <= pend_nv_d;
      third_q <= third_d;
      lock_q <= lock_d;
      wel_q <= wel_d;
      busy_q <= busy_d;
      sus_q <= sus_d;
      vwe_q <= vwe_d;
      volw_q <= volw_d;
      arm_q <= arm_d;
      qpi_q <= qpi_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ********************************************************************
  // assertions
  // ********************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_wel_set_enable: assert property (
    accept && cmd.opcode == OP_WRITE_ENABLE |=> wel_q && status.first_status_register[1])
    else $error("write enable did not set the latch");
  a_busy_clears_done: assert property (
    busy_q && op_done && !op_suspended |=> !busy_q && !wel_q)
    else $error("busy or latch survived completion");
  a_busy_ignores_cmd: assert property (
    busy_q && cmd.valid && !is_read(cmd.opcode) && !op_done && !op_suspended
    |=> $stable(nv_q) && $stable(vol_q) && $stable(third_q) && busy_q)
    else $error("command acted on while busy");
  a_ro_bits_kept: assert property (
    !busy_q && vwe_q && cmd.valid && cmd.opcode == OP_WRITE_FIRST && !op_resumed
    |=> !busy_q && $stable(wel_q) && $stable(sus_q))
    else $error("volatile write touched a read-only flag");
  a_nv_after_vol: assert property (
    volw_q && !busy_q && !vwe_q && cmd.valid && cmd.opcode == OP_WRITE_FIRST && !op_resumed
    |=> !busy_q ##1 $stable(nv_q))
    else $error("non-volatile write accepted after volatile write");
  a_vol_write_copy: assert property (
    !busy_q && vwe_q && cmd.valid && cmd.opcode == OP_WRITE_FIRST && wr_allowed(vol_q, write_protect_n)
    |=> vol_q.protect_range == $past(cmd.data[B_RANGE_MSB:B_RANGE_LSB]) && $stable(nv_q))
    else $error("volatile write did not land in the volatile copy");
  a_latency_restore: assert property (
    qpi_q && accept && cmd.opcode == OP_QPI_EXIT |=> !qpi_q && third_q.read_latency_field == LC_RESET)
    else $error("latency not restored on leaving quad-peripheral mode");
  a_pin_fn_quad: assert property (
    vol_q.quad_enable |-> !cfg.hold_fn_en && !cfg.reset_fn_en && !cfg.wp_fn_en)
    else $error("pin function active with quad enabled");
  a_lock_zero_set: assert property (
    status.second_status_register[B_LOCK_LSB] && cfg.security_lock[0])
    else $error("security register zero not shown locked");
  a_fixed_latency: assert property (
    third_q.read_latency_field == LC_FIXED |-> !cfg.variable_latency_en)
    else $error("variable latency enabled with zero field");
  a_read_answer: assert property (
    cmd.valid && cmd.opcode == OP_READ_FIRST |=> rd_valid && rd_data[1:0] == $past({wel_q, busy_q}))
    else $error("status read not answered while busy or idle");
endmodule : fsr_status_bank
`default_nettype wire
